// ### verilog/rps_rx_port.sv
// Client receive port output stage, pipelined timing mode.
// Assumes symbols arrive from the controller side as valid/ready words and that
// the client samples type and symbol on the same clock as this logic.
//
// Notes on behaviour
// - Hold on first non-null after null inserts null.
// - Inserted null halves rate, loses nothing.
// - Row 9 always presents null next.
// - Held port stays in rows 8,7,11, or in row 5 until a word arrives.
// - Row 10 symbol cannot be held.
// - Row 10 entered only from row 3.
// - Row 10 symbol shows exactly two cycles.
// - Workaround one confines rows 1,2,9.
// - Workaround one: non-null type one cycle.
// - Workaround one alternates rows 9 and 2.
// - Volatile flag marks unholdable bus symbol.
// - Previous-hold flag registers last hold input.
// - Advance loads bus, otherwise bus kept.
// - Type code describes next bus symbol.
// - Hold freezes only non-null symbols.
// - Unheld type at t describes bus t+1.
`timescale 1ns/100ps
`include "rps_regs.svh"

module rps_rx_port
	import rps_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire rps_sym_t rx_sym_in,
	input wire logic rx_valid_in,
	output logic rx_ready_out,
	input wire logic receive_hold_n_in,
	output logic [`RPS_TYPE_W-1:0] receive_type_code_out,
	output logic [`RPS_SYM_W-1:0] receive_symbol_bus_out
);

	// ==========================================================
	// Pipeline FIFO
	rps_sym_t fifo_head;
	logic fifo_valid;
	logic fifo_pop;
	logic fifo_wr_valid;

	// Null words carry nothing; they are accepted and dropped at the door
	assign fifo_wr_valid = rx_valid_in && (rx_sym_in.kind != `RPS_TYPE_NULL);

	rps_fifo #(
		.WIDTH($bits(rps_sym_t)),
		.DEPTH(`RPS_FIFO_DEPTH),
		.AW(`RPS_FIFO_AW)
	) u_fifo (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.wr_data_in(rx_sym_in),
		.wr_valid_in(fifo_wr_valid),
		.wr_ready_out(rx_ready_out),
		.rd_data_out(fifo_head),
		.rd_valid_out(fifo_valid),
		.rd_ready_in(fifo_pop)
	);

	// ==========================================================
	// Port state
	logic hold;
	logic [`RPS_TYPE_W-1:0] type_code;
	logic output_volatile;
	logic hold_prev;
	logic [`RPS_SYM_W-1:0] symbol_bus;
	logic [`RPS_SYM_W-1:0] pending_sym;
	logic [`RPS_TYPE_W-1:0] next_type_code;
	logic output_volatile_next;
	logic next_hold_prev;
	logic [`RPS_SYM_W-1:0] next_symbol_bus;
	logic [`RPS_SYM_W-1:0] next_pending_sym;
	logic output_new_symbol;
	logic output_unchanged;
	logic type_null;
	rps_row_t row;

	assign hold = !receive_hold_n_in;
	assign type_null = (type_code == `RPS_TYPE_NULL);
	assign output_unchanged = !output_new_symbol;
	assign receive_type_code_out = type_code;
	assign receive_symbol_bus_out = symbol_bus;

	always_comb begin
		next_type_code = type_code;
		output_volatile_next = output_volatile;
		next_hold_prev = hold;
		output_new_symbol = 1'b0;
		fifo_pop = 1'b0;
		row = ROW_1;
		if (!hold) begin
			if (type_null) begin
				output_volatile_next = 1'b1;
				next_type_code = `RPS_TYPE_NULL;
				row = ROW_1;
				if (fifo_valid) begin
					next_type_code = fifo_head.kind;
					fifo_pop = 1'b1;
					row = ROW_2;
				end
			end else begin
				output_volatile_next = 1'b0;
				output_new_symbol = 1'b1;
				next_type_code = `RPS_TYPE_NULL;
				row = ROW_3;
				if (fifo_valid) begin
					next_type_code = fifo_head.kind;
					fifo_pop = 1'b1;
					row = ROW_4;
				end
			end
		end else if (!type_null) begin
			if (output_volatile) begin
				// nothing is popped, so nothing is lost
				next_type_code = `RPS_TYPE_NULL;
				output_volatile_next = 1'b0;
				output_new_symbol = 1'b1;
				row = ROW_9;
			end else begin
				row = ROW_8;
			end
		end else if (output_volatile) begin
			next_type_code = `RPS_TYPE_NULL;
			row = ROW_5;
			if (fifo_valid) begin
				next_type_code = fifo_head.kind;
				fifo_pop = 1'b1;
				row = ROW_6;
			end
		end else if (hold_prev) begin
			next_type_code = `RPS_TYPE_NULL;
			row = fifo_valid ? ROW_7 : ROW_11;
		end else begin
			next_type_code = `RPS_TYPE_NULL;
			row = ROW_11;
			if (fifo_valid) begin
				// every exit from row ten advances
				next_type_code = fifo_head.kind;
				output_volatile_next = 1'b1;
				fifo_pop = 1'b1;
				row = ROW_10;
			end
		end
	end

	always_comb begin
		next_symbol_bus = output_new_symbol ? pending_sym : symbol_bus;
		next_pending_sym = fifo_pop ? fifo_head.data : pending_sym;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			type_code <= `RPS_TYPE_NULL;
			output_volatile <= 1'b1;
			hold_prev <= 1'b0;
			symbol_bus <= 32'h0000_0000;
			pending_sym <= 32'h0000_0000;
		end else begin
			type_code <= next_type_code;
			output_volatile <= output_volatile_next;
			hold_prev <= next_hold_prev;
			symbol_bus <= next_symbol_bus;
			pending_sym <= next_pending_sym;
		end
	end

	// ==========================================================
	// Checks
	logic [`RPS_TYPE_W-1:0] bus_kind;

	// Type of the symbol now on the bus, only for the checks
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			bus_kind <= `RPS_TYPE_NULL;
		end else if (output_new_symbol) begin
			bus_kind <= type_code;
		end
	end

	row_nine_null_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(row == ROW_9) |=> (receive_type_code_out == `RPS_TYPE_NULL) && !output_volatile)
		else $error("row 9 did not present a null type");

	null_insert_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(hold && output_volatile && !type_null && fifo_valid) |-> !fifo_pop ##1 type_null)
		else $error("null not inserted after hold on first non-null");

	hold_freeze_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(hold && !type_null && !output_volatile) |=> $stable(receive_symbol_bus_out) && !type_null)
		else $error("held non-null symbol moved");

	advance_load_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		output_new_symbol |=> receive_symbol_bus_out == $past(pending_sym))
		else $error("advance did not load pending symbol");

	bus_keep_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		output_unchanged |=> $stable(receive_symbol_bus_out))
		else $error("bus changed without advance");

	prev_hold_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		##1 hold_prev == $past(hold))
		else $error("previous-hold flag wrong");

	type_lead_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(!hold && !type_null) |=> bus_kind == $past(type_code))
		else $error("type code did not describe next bus symbol");

	idle_volatile_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(!hold && type_null && !fifo_valid) |=> output_volatile && type_null && $stable(receive_symbol_bus_out))
		else $error("idle port not volatile and null");

	row_ten_entry_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(row == ROW_10) |-> $past(row == ROW_3))
		else $error("row 10 entered from other than row 3");

	row_ten_two_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(row == ROW_3) ##1 (row == ROW_10) |=> output_new_symbol)
		else $error("row 10 symbol not advanced after two cycles");

	reset_state_a: assert property (@(posedge clk_sys_in)
		$rose(resetn_in) |-> type_null && output_volatile && !hold_prev)
		else $error("wrong state after reset");

	// Row ten leaves the bus exposed, so the flag must say so at once
	row_ten_volatile_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(row == ROW_10) |=> output_volatile)
		else $error("row 10 did not mark bus volatile");

	held_rows_null_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(hold && type_null && !output_volatile && hold_prev) |=> type_null)
		else $error("held port revealed an arrival");

	row_nine_keep_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(row == ROW_9) |-> !fifo_pop)
		else $error("row 9 popped a symbol");

	null_pass_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(hold && type_null && output_volatile && fifo_valid) |=> !type_null && $stable(receive_symbol_bus_out))
		else $error("hold blocked a null output");

	row_ten_keep_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(row == ROW_10) |=> $stable(receive_symbol_bus_out))
		else $error("row 10 symbol left too early");

	row_ten_c: cover property (@(posedge clk_sys_in) disable iff (!resetn_in) (row == ROW_10));
	row_nine_two_c: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
		(row == ROW_9) ##1 (row == ROW_2) ##1 (row == ROW_9));
	streaming_c: cover property (@(posedge clk_sys_in) disable iff (!resetn_in) (row == ROW_4) [*4]);
	fifo_full_c: cover property (@(posedge clk_sys_in) disable iff (!resetn_in) !rx_ready_out);
	held_seven_c: cover property (@(posedge clk_sys_in) disable iff (!resetn_in) (row == ROW_7));

endmodule

// ### verilog/rps_regs.svh
// Constants for the client receive port output stage.
// Assumes inclusion by bare name from the package and design modules.
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

// ==========================================================
// Type codes on the receive type code lines
`define RPS_TYPE_HEAD 2'h0
`define RPS_TYPE_DATA 2'h1
`define RPS_TYPE_FRAME 2'h2
`define RPS_TYPE_NULL 2'h3

// ==========================================================
// Widths and depths
`define RPS_SYM_W 32
`define RPS_TYPE_W 2
`define RPS_FIFO_DEPTH 32
`define RPS_FIFO_AW 5

`endif

// ### verilog/rps_pkg.sv
// Types shared by the receive port output stage, its client model and the bench.
// Assumes rps_regs.svh is on the include path.
`include "rps_regs.svh"

package rps_pkg;

	// ==========================================================
	// Symbol with its type code
	typedef struct packed {
		logic [`RPS_TYPE_W-1:0] kind;
		logic [`RPS_SYM_W-1:0] data;
	} rps_sym_t;

	// ==========================================================
	// Decoded row of the port state table, used for coverage
	typedef enum logic [3:0] {
		ROW_1, ROW_2, ROW_3, ROW_4, ROW_5, ROW_6, ROW_7, ROW_8, ROW_9, ROW_10, ROW_11
	} rps_row_t;

endpackage

// ### verilog/rps_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`include "rps_regs.svh"

module rps_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = `RPS_FIFO_DEPTH,
	parameter int AW = `RPS_FIFO_AW
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic do_wr;
	logic do_rd;

	assign wr_ready_out = (count != DEPTH[AW:0]);
	assign rd_valid_out = (count != '0);
	assign rd_data_out = mem[rd_ptr];
	assign do_wr = wr_valid_in && wr_ready_out;
	assign do_rd = rd_valid_out && rd_ready_in;

	// ==========================================================
	// Pointers and fill level
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (do_wr) begin
			next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
		end
		if (do_rd) begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
		end
		if (do_wr && !do_rd) begin
			next_count = (AW+1)'(count + 1'b1);
		end else if (do_rd && !do_wr) begin
			next_count = (AW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage needs no reset; reads are gated by the fill level
	always_ff @(posedge clk_sys_in) begin
		if (do_wr) begin
			mem[wr_ptr] <= wr_data_in;
		end
	end

endmodule

// ### tb/rps_client.sv
// Client-side partner for the receive port: drives the hold request and
// records each word as it lands on the bus. Assumes pipelined timing.
`timescale 1ns/100ps
`include "rps_regs.svh"

module rps_client
	import rps_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [1:0] mode_in,
	input wire logic [`RPS_TYPE_W-1:0] receive_type_code_in,
	input wire logic [`RPS_SYM_W-1:0] receive_symbol_bus_in,
	output logic receive_hold_n_out,
	output logic cap_valid_out,
	output rps_sym_t cap_sym_out
);
	logic [`RPS_TYPE_W-1:0] prev_type;
	logic [`RPS_TYPE_W-1:0] next_prev_type;

	// ==========================================================
	// Type history
	always_comb begin
		next_prev_type = resetn_in ? receive_type_code_in : `RPS_TYPE_NULL;
	end

	always_ff @(posedge clk_sys_in) begin
		prev_type <= next_prev_type;
	end

	// copy saved from one-cycle-late type
	// Taken at once, so a word never needs more than one bus cycle
	assign cap_valid_out = prev_type != `RPS_TYPE_NULL;
	assign cap_sym_out = '{kind: prev_type, data: receive_symbol_bus_in};

	// ==========================================================
	// Hold policy
	always_comb begin
		case (mode_in)
			2'h0: receive_hold_n_out = 1'b1;
			2'h1: receive_hold_n_out = receive_type_code_in == `RPS_TYPE_NULL;
			2'h2: receive_hold_n_out = prev_type == `RPS_TYPE_NULL;
			default: receive_hold_n_out = 1'b0;
		endcase
	end
endmodule

// ### tb/rx_port_stall_control_tb.sv
// Self-checking bench for the receive port output stage.
// Assumes the design files and rps_client are compiled first.
`timescale 1ns/100ps
`include "rps_regs.svh"

module rx_port_stall_control_tb
	import rps_pkg::*;
;
	logic clk_sys_in;
	logic resetn_in;
	rps_sym_t rx_sym_in;
	logic rx_valid_in;
	logic rx_ready_out;
	logic hold_n;
	logic [1:0] type_code;
	logic [31:0] bus;
	logic [1:0] mode;
	logic cap_valid;
	rps_sym_t cap_sym;
	logic [1:0] prev_tc;
	rps_sym_t exp_q[$];
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;
	int last_cap = 0;
	int exp_gap = 0;

	rps_rx_port u_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .rx_sym_in(rx_sym_in),
		.rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out), .receive_hold_n_in(hold_n),
		.receive_type_code_out(type_code), .receive_symbol_bus_out(bus));
	rps_client u_client (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .mode_in(mode),
		.receive_type_code_in(type_code), .receive_symbol_bus_in(bus), .receive_hold_n_out(hold_n),
		.cap_valid_out(cap_valid), .cap_sym_out(cap_sym));

	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end

	// ==========================================================
	// Shared tasks
	task automatic step();
		@(posedge clk_sys_in);
		#1;
	endtask

	task automatic check(input logic [33:0] got, input logic [33:0] want);
		n_compared++;
		if (got !== want) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic end_of_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic timeout();
		n_fail++;
		end_of_test();
	endtask

	// Leaves valid high so back-to-back words need no gap
	task automatic push(input logic [1:0] k, input logic [31:0] d);
		int i;
		rx_sym_in = '{kind: k, data: d};
		rx_valid_in = 1'b1;
		for (i = 0; i < 50 && rx_ready_out !== 1'b1; i++) step();
		if (i == 50) timeout();
		if (k != `RPS_TYPE_NULL) exp_q.push_back(rx_sym_in);
		step();
	endtask

	task automatic wait_empty();
		int i;
		for (i = 0; i < 200 && exp_q.size() != 0; i++) step();
		if (i == 200) timeout();
	endtask

	// ==========================================================
	// Capture monitor: order, type and spacing of delivered words
	always @(negedge clk_sys_in) begin
		cyc++;
		if (resetn_in === 1'b1 && mode == 2'h1 && type_code !== `RPS_TYPE_NULL) begin
			check(34'(prev_tc), 34'(`RPS_TYPE_NULL));
		end
		if (cap_valid === 1'b1) begin
			check(cap_sym, exp_q.size() > 0 ? exp_q.pop_front() : ~cap_sym);
			if (exp_gap != 0 && cyc - last_cap < 8) check(34'(cyc - last_cap), 34'(exp_gap));
			last_cap = cyc;
		end
		prev_tc = type_code;
	end

	// ==========================================================
	// Scenarios
	task automatic t_stream();
		logic [31:0] held;
		mode = 2'h0;
		exp_gap = 1;
		push(`RPS_TYPE_NULL, 32'h0BAD_0000);
		for (int i = 0; i < 9; i++) push(2'(i % 3), 32'hA500_0000 + i);
		rx_valid_in = 1'b0;
		wait_empty();
		exp_gap = 0;
		held = bus;
		repeat (4) begin
			step();
			check(34'(type_code), 34'(`RPS_TYPE_NULL));
			check(34'(bus), 34'(held));
		end
	endtask

	// Fill while the client holds, then drain with the workaround-one client that holds on non-null types
	task automatic t_fill_drain();
		int acc;
		acc = 0;
		mode = 2'h3;
		for (int i = 0; i < 40; i++) begin
			rx_sym_in = '{kind: `RPS_TYPE_DATA, data: 32'hF000_0000 + acc};
			rx_valid_in = 1'b1;
			if (rx_ready_out === 1'b1) begin
				acc++;
				exp_q.push_back(rx_sym_in);
			end
			step();
		end
		rx_valid_in = 1'b0;
		check(34'(rx_ready_out), 34'h0);
		check(34'(acc >= 32 && acc <= 34), 34'h1);
		mode = 2'h1;
		exp_gap = 2;
		wait_empty();
		exp_gap = 0;
		check(34'(rx_ready_out), 34'h1);
	endtask

	task automatic t_row10();
		int n;
		mode = 2'h2;
		repeat (3) step();
		push(`RPS_TYPE_HEAD, 32'h5EED_0001);
		rx_valid_in = 1'b0;
		step();
		push(`RPS_TYPE_FRAME, 32'h5EED_0002);
		rx_valid_in = 1'b0;
		for (n = 0; n < 10 && bus !== 32'h5EED_0001; n++) step();
		if (n == 10) timeout();
		for (n = 0; n < 6 && bus === 32'h5EED_0001; n++) step();
		check(34'(n), 34'h2);
		check(34'(bus), 34'h5EED_0002);
		wait_empty();
	endtask

	initial begin
		rx_sym_in = '0;
		rx_valid_in = 1'b0;
		resetn_in = 1'b0;
		mode = 2'h0;
		repeat (16) @(posedge clk_sys_in);
		#1;
		check(34'(type_code), 34'(`RPS_TYPE_NULL));
		check(34'(bus), 34'h0);
		check(34'(rx_ready_out), 34'h1);
		resetn_in = 1'b1;
		t_stream();
		t_fill_drain();
		t_row10();
		end_of_test();
	end
endmodule
